// ==== design/srg_pkg.sv ====
/*
 * Package for the supervisory reset generator: timing constants, output variants, line state types.
 * Assumes a 100 MHz system clock.
 */
package srg_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MR_GLITCH_NS = 100;
	localparam int MR_GLITCH_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PU_ONESHOT_NS = 2000;
	localparam int PU_ONESHOT_CYC = PU_ONESHOT_NS / CLK_PERIOD_NS;
	localparam int LINE_SAMPLE_NS = 500;
	localparam int LINE_SAMPLE_CYC = LINE_SAMPLE_NS / CLK_PERIOD_NS;
	localparam int HOLD_OFF_MS = 140;
	localparam int HOLD_OFF_CYC_DEF = HOLD_OFF_MS * 100000;
	localparam int WDOG_MS = 1600;
	localparam int WDOG_CYC_DEF = WDOG_MS * 100000;
	localparam int FLOAT_NUM = 7;
	localparam int FLOAT_DEN = 8;
	localparam int CNT_W = 32;
	localparam int MR_CNT_W = 8;
	localparam int PU_CNT_W = 8;

	typedef enum logic [1:0] {
		SRG_OUT_PUSH_PULL = 2'h0,
		SRG_OUT_OPEN_DRAIN = 2'h1,
		SRG_OUT_BIDIR = 2'h2
	} srg_variant_t;

	typedef enum logic [2:0] {
		SRG_ST_ASSERT = 3'h1,
		SRG_ST_HOLD = 3'h2,
		SRG_ST_RUN = 3'h4
	} srg_state_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic passive_pu_en;
		logic active_pu_en;
	} srg_line_drive_t;

	typedef struct packed {
		logic below_arm;
		logic below_high;
	} srg_line_sense_t;
endpackage

// ==== design/srg_top.sv ====
/*
 * Supervisory reset generator: supply, manual and watchdog sources, hold-off timer,
 * push/pull, open-drain and bidirectional reset line with active pullup sequencing.
 * Assumes analogue comparators on supply, line and kick pins deliver asynchronous
 * logic levels; kick floating is reported by an external sense comparator.
 * The line comparators report below the arm threshold and below the high level
 * of the shared reset line; the pad turns oe/out into a sink and the pullup
 * enables into the passive resistor and the active pullup switch.
 * Hold-off and watchdog periods count system clocks, so sub-cycle figures round
 * up to whole cycles; comparator and pad delays add to every figure.
 * Supply glitch immunity and pad strengths are outside this block.
 */
//
// Contract
// [RULE1] Hold reset a full hold-off period after every source clears; a foreign line pull is timed from when the device starts to sink.
// [RULE2] Assert reset while manual request is held low.
// [RULE3] After manual request rises, hold reset one hold-off period.
// [RULE4] Assert reset when kick stays constant a whole watchdog period.
// [RULE5] Clear watchdog counter on reset and on any kick edge.
// [RULE6] Floating or three-stated kick input disables the watchdog.
// [RULE7] At hold-off expiry release reset and restart watchdog from zero.
// [RULE8] Watchdog counter held cleared while reset asserted.
// [RULE9] Floating kick clears watchdog internally every seven eighths period.
// [RULE10] Active-high output is always inverse of active-low output.
// [RULE11] Line pulled low by another party counts as reset.
// [RULE12] Line below arm threshold sets the transition flip-flop.
// [RULE13] Active pullup on between arm and high level, off after 2 us.
// [RULE14] Pullup sequence runs for every reset source.
// [RULE15] Passive pullup disconnected while device asserts reset.
// [RULE16] Processor drives line low four clocks, releases, samples after two.
// [RULE17] Processor decides reset source from sampled line level.
// [RULE18] Line returns high within processor sampling window of 500 ns.
// [RULE19] Open-drain output sinks only while reset asserted.
// [RULE20] Manual request input is pulled high internally.
// [RULE21] Manual request rejects 100 ns negative glitches; no debounce needed.
// [RULE22] Hold-off and watchdog periods are build-time parameters.
`timescale 1ns/1ps
module srg_top #(
	parameter int HOLD_OFF_CYC = srg_pkg::HOLD_OFF_CYC_DEF,
	parameter int WDOG_CYC = srg_pkg::WDOG_CYC_DEF,
	parameter srg_pkg::srg_variant_t VARIANT = srg_pkg::SRG_OUT_BIDIR
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic supply_low_i,
	input wire logic manual_request_n_i,
	input wire logic watchdog_kick_in_i,
	input wire logic kick_float_i,
	input wire srg_pkg::srg_line_sense_t line_sense_i,
	input wire logic line_i,
	output logic reset_n_o,
	output logic reset_o,
	output srg_pkg::srg_line_drive_t line_drive_o,
	output logic manual_pullup_en_o
);
	// Counters compare against the last value, so a period of N cycles takes N edges
	localparam logic [srg_pkg::CNT_W-1:0] HOLD_LAST = srg_pkg::CNT_W'(HOLD_OFF_CYC - 1);
	localparam logic [srg_pkg::CNT_W-1:0] WDOG_LAST = srg_pkg::CNT_W'(WDOG_CYC - 1);
	localparam logic [srg_pkg::CNT_W-1:0] FLOAT_LAST =
		srg_pkg::CNT_W'((longint'(WDOG_CYC) * srg_pkg::FLOAT_NUM) / srg_pkg::FLOAT_DEN - 1);
	localparam logic [srg_pkg::MR_CNT_W-1:0] MR_LAST = srg_pkg::MR_CNT_W'(srg_pkg::MR_GLITCH_CYC - 1);
	localparam logic [srg_pkg::PU_CNT_W-1:0] PU_LAST = srg_pkg::PU_CNT_W'(srg_pkg::PU_ONESHOT_CYC - 1);

	// Two-stage synchronisers for every pin-level input
	// Reset values stand for an idle board: manual request released, supply good,
	// line held low by our own sink.
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	assign async_in = {supply_low_i, manual_request_n_i, watchdog_kick_in_i, kick_float_i,
		line_sense_i.below_arm, line_sense_i.below_high, line_i};

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sync1_q <= 7'h3C;
			sync2_q <= 7'h3C;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	logic supply_low_s, mr_n_s, kick_s, kick_float_s, below_arm_s, below_high_s, line_s;
	assign {supply_low_s, mr_n_s, kick_s, kick_float_s, below_arm_s, below_high_s, line_s} = sync2_q;

	// Manual request glitch filter: low must persist before it counts
	// A bounce longer than the filter only restarts the hold-off, so a plain
	// switch needs no external debounce.
	logic [srg_pkg::MR_CNT_W-1:0] mr_cnt_q;
	logic mr_active_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mr_cnt_q <= 8'h00;
			mr_active_q <= 1'b0;
		end else if (mr_n_s) begin
			mr_cnt_q <= 8'h00;
			mr_active_q <= 1'b0;
		end else if (mr_cnt_q == MR_LAST) begin
			mr_active_q <= 1'b1; // [RULE2] [RULE21]
		end else begin
			mr_cnt_q <= mr_cnt_q + 8'h01;
		end
	end

	// Pin pullup is analogue; this level only enables it
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			manual_pullup_en_o <= 1'b1;
		end else begin
			manual_pullup_en_o <= 1'b1; // [RULE20]
		end
	end

	// A foreign pull is only a fall from a line seen high since we let go;
	// a line still charging after our own release must not look like one.
	logic line_up_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			line_up_q <= 1'b0;
		end else if (line_drive_o.oe) begin
			line_up_q <= 1'b0;
		end else if (line_s) begin
			line_up_q <= 1'b1;
		end
	end

	// Line pulled low by someone else while we are not driving it
	logic ext_pull;
	assign ext_pull = (VARIANT == srg_pkg::SRG_OUT_BIDIR) && line_up_q && !line_s && !line_drive_o.oe; // [RULE11]

	logic hold_src;
	assign hold_src = supply_low_s || mr_active_q || ext_pull;

	// Reset sequencer
	// Any cause seen in HOLD restarts the full hold-off; RUN clears the count so
	// that a watchdog-caused hold starts from zero too.
	// State decode shared by the watchdog and the output stages
	function automatic logic is_running(input srg_pkg::srg_state_t st);
		return st == srg_pkg::SRG_ST_RUN;
	endfunction

	srg_pkg::srg_state_t state_q;
	logic [srg_pkg::CNT_W-1:0] hold_cnt_q;
	logic [srg_pkg::CNT_W-1:0] wd_cnt_q;
	logic [srg_pkg::CNT_W-1:0] float_cnt_q;
	logic kick_prev_q;
	logic wd_timeout;
	assign wd_timeout = is_running(state_q) && (wd_cnt_q == WDOG_LAST);

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_q <= srg_pkg::SRG_ST_ASSERT;
			hold_cnt_q <= 32'h0000_0000;
		end else begin
			unique case (state_q)
				srg_pkg::SRG_ST_ASSERT: begin
					hold_cnt_q <= 32'h0000_0000;
					if (!hold_src) begin
						state_q <= srg_pkg::SRG_ST_HOLD; // [RULE3]
					end
				end
				srg_pkg::SRG_ST_HOLD: begin
					if (hold_src) begin
						state_q <= srg_pkg::SRG_ST_ASSERT;
						hold_cnt_q <= 32'h0000_0000;
					end else if (hold_cnt_q == HOLD_LAST) begin
						state_q <= srg_pkg::SRG_ST_RUN; // [RULE7]
					end else begin
						hold_cnt_q <= hold_cnt_q + 32'h0000_0001; // [RULE1] [RULE22]
					end
				end
				srg_pkg::SRG_ST_RUN: begin
					hold_cnt_q <= 32'h0000_0000; // [RULE1]
					if (hold_src) begin
						state_q <= srg_pkg::SRG_ST_ASSERT;
					end else if (wd_timeout) begin
						state_q <= srg_pkg::SRG_ST_HOLD; // [RULE4] [RULE1]
					end
				end
				default: state_q <= srg_pkg::SRG_ST_ASSERT;
			endcase
		end
	end

	logic in_reset;
	assign in_reset = !is_running(state_q);

	// Watchdog counter; floating input serviced by an internal 7/8-period strobe
	// The edge detector tracks the pin during reset too, so the first edge
	// after release is a real one.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			kick_prev_q <= 1'b0;
			wd_cnt_q <= 32'h0000_0000;
			float_cnt_q <= 32'h0000_0000;
		end else begin
			kick_prev_q <= kick_s;
			if (in_reset || wd_timeout) begin
				wd_cnt_q <= 32'h0000_0000; // [RULE5] [RULE8] [RULE7]
				float_cnt_q <= 32'h0000_0000;
			end else if (kick_float_s) begin
				wd_cnt_q <= wd_cnt_q + 32'h0000_0001; // [RULE6]
				if (float_cnt_q == FLOAT_LAST) begin
					float_cnt_q <= 32'h0000_0000;
					wd_cnt_q <= 32'h0000_0000; // [RULE9]
				end else begin
					float_cnt_q <= float_cnt_q + 32'h0000_0001;
				end
			end else if (kick_s != kick_prev_q) begin
				wd_cnt_q <= 32'h0000_0000; // [RULE5]
				float_cnt_q <= 32'h0000_0000;
			end else begin
				wd_cnt_q <= wd_cnt_q + 32'h0000_0001; // [RULE4]
				float_cnt_q <= 32'h0000_0000;
			end
		end
	end

	// Push/pull outputs, one the inverse of the other
	// Both leave the same flop stage, so they never disagree for a cycle.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			reset_n_o <= 1'b0;
			reset_o <= 1'b1;
		end else begin
			reset_n_o <= !in_reset;
			reset_o <= in_reset; // [RULE10]
		end
	end

	// Bidirectional line: transition flip-flop and 2 us one-shot pullup
	// The one-shot bounds the strong pullup even on a shorted line; without it
	// the switch could fight a sink for ever.
	logic trans_q;
	logic pu_active_q;
	logic [srg_pkg::PU_CNT_W-1:0] pu_cnt_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			trans_q <= 1'b0;
			pu_active_q <= 1'b0;
			pu_cnt_q <= 8'h00;
		end else if (below_arm_s) begin
			trans_q <= 1'b1; // [RULE12] [RULE14]
			pu_active_q <= 1'b0;
			pu_cnt_q <= 8'h00;
		end else if (trans_q && !in_reset && !pu_active_q) begin
			trans_q <= 1'b0;
			pu_active_q <= below_high_s; // [RULE13]
			pu_cnt_q <= 8'h00;
		end else if (pu_active_q) begin
			if (!below_high_s || pu_cnt_q == PU_LAST) begin
				pu_active_q <= 1'b0; // [RULE13] [RULE18]
			end else begin
				pu_cnt_q <= pu_cnt_q + 8'h01;
			end
		end
	end

	// Pin drive per variant; oe high with out low means the device sinks the line
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			line_drive_o <= '{out: 1'b0, oe: 1'b1, passive_pu_en: 1'b0, active_pu_en: 1'b0};
		end else begin
			// Variant is a build-time constant, so only one arm remains in hardware
			unique case (VARIANT)
				srg_pkg::SRG_OUT_PUSH_PULL: begin
					line_drive_o <= '{
						out: !in_reset,
						oe: 1'b1,
						passive_pu_en: 1'b0,
						active_pu_en: 1'b0
					};
				end
				srg_pkg::SRG_OUT_OPEN_DRAIN: begin
					line_drive_o <= '{
						out: 1'b0,
						oe: in_reset, // [RULE19]
						passive_pu_en: 1'b0,
						active_pu_en: 1'b0
					};
				end
				default: begin
					line_drive_o <= '{
						out: 1'b0,
						oe: in_reset,
						passive_pu_en: !in_reset, // [RULE15]
						active_pu_en: pu_active_q && below_high_s && !in_reset // [RULE13]
					};
				end
			endcase
		end
	end
endmodule

// ==== verification/srg_chk_sva.sv ====
/* Port checker for srg_top.
   Assumes the bidirectional variant and short periods. */
`timescale 1ns/1ps
module srg_chk #(
	parameter int HOLD_OFF_CYC = 50,
	parameter int WDOG_CYC = 400
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic supply_low_i,
	input wire logic manual_request_n_i,
	input wire logic watchdog_kick_in_i,
	input wire logic kick_float_i,
	input wire logic line_i,
	input wire srg_pkg::srg_line_sense_t line_sense_i,
	input wire logic reset_n_o,
	input wire logic reset_o,
	input wire srg_pkg::srg_line_drive_t line_drive_o
);
	int qt_q, src_q, wd_q, pu_q;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	always_ff @(posedge clk_sys_i) begin
		qt_q <= (sys_rst_i || supply_low_i || !manual_request_n_i) ? 0 : qt_q + 1;
	end
	// A foreign pull on the line is a cause too, so it restarts this age
	always_ff @(posedge clk_sys_i) begin
		src_q <= (sys_rst_i || supply_low_i || !manual_request_n_i || (!line_i && !line_drive_o.oe)) ? 0 : src_q + 1;
	end
	always_ff @(posedge clk_sys_i) begin
		wd_q <= (!reset_n_o || kick_float_i || watchdog_kick_in_i != $past(watchdog_kick_in_i)) ? 0 : wd_q + 1;
	end
	always_ff @(posedge clk_sys_i) begin
		pu_q <= line_drive_o.active_pu_en ? pu_q + 1 : 0;
	end
	inv_out_a: assert property (reset_o == !reset_n_o) else $error("not inverse");
	hold_off_a: assert property ($rose(reset_n_o) |-> qt_q >= HOLD_OFF_CYC) else $error("short hold");
	wd_late_a: assert property (reset_n_o && !kick_float_i |-> wd_q <= WDOG_CYC + 8) else $error("late dog");
	wd_early_a: assert property ($fell(reset_n_o) |-> src_q < 24 ||
		($past(wd_q) + 8 >= WDOG_CYC && !$past(kick_float_i))) else $error("no cause");
	pp_off_a: assert property (!reset_n_o && !$past(reset_n_o) |-> !line_drive_o.passive_pu_en)
		else $error("passive on");
	sink_a: assert property (reset_n_o && $past(reset_n_o) |-> !line_drive_o.oe) else $error("sinking");
	pu_shot_a: assert property (line_drive_o.active_pu_en |-> pu_q <= srg_pkg::PU_ONESHOT_CYC)
		else $error("long pullup");
	pu_fire_a: assert property ($fell(line_sense_i.below_arm) && reset_n_o |->
		##[1:6] line_drive_o.active_pu_en) else $error("no pullup");
endmodule
bind srg_top srg_chk #(.HOLD_OFF_CYC(HOLD_OFF_CYC), .WDOG_CYC(WDOG_CYC)) srg_chk_inst (.clk_sys_i, .sys_rst_i,
	.supply_low_i, .manual_request_n_i, .watchdog_kick_in_i, .kick_float_i, .line_i, .line_sense_i, .reset_n_o, .reset_o,
	.line_drive_o);

// ==== verification/srg_mcu_model.sv ====
/* Processor on the shared reset line: line charge, own pulldown, source sampling.
   Assumes 25 system cycles per processor clock. */
`timescale 1ns/1ps
module srg_mcu_model (
	input wire logic clk_sys_i,
	input wire logic pull_req_i,
	input wire srg_pkg::srg_line_drive_t line_drive_i,
	output logic line_o,
	output srg_pkg::srg_line_sense_t line_sense_o,
	output logic self_caused_o
);
	int chg_q = 0;
	int seq_q = 0;
	// Passive charge alone misses the sampling window
	always_ff @(posedge clk_sys_i) begin
		if ((line_drive_i.oe && !line_drive_i.out) || (seq_q > 0 && seq_q <= 100)) begin
			chg_q <= 0;
		end else begin
			chg_q <= chg_q + (line_drive_i.active_pu_en ? 16 : 1);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		seq_q <= pull_req_i ? 1 : (seq_q > 0 && seq_q < 150) ? seq_q + 1 : 0;
		if (seq_q == 150) begin
			self_caused_o <= line_o;
		end
	end
	assign line_o = chg_q >= 64;
	assign line_sense_o = '{below_arm: chg_q < 4, below_high: chg_q < 68};
endmodule

// ==== verification/tb.sv ====
/* Self-checking bench for srg_top, bidirectional variant.
   Assumes the processor model and the bound checker. */
`timescale 1ns/1ps
module tb;
	localparam int HOLD = 50;
	localparam int WDOG = 400;
	logic clk_sys_i = 0, sys_rst_i = 1, supply_low_i = 0, manual_request_n_i = 1, watchdog_kick_in_i = 0;
	logic kick_float_i = 0, line_i, reset_n_o, reset_o, manual_pullup_en_o, pull_req = 0, self_c, kick_en = 0;
	srg_pkg::srg_line_sense_t line_sense_i;
	srg_pkg::srg_line_drive_t line_drive_o;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, n, gap;
	always #5 clk_sys_i = ~clk_sys_i;
	srg_top #(.HOLD_OFF_CYC(HOLD), .WDOG_CYC(WDOG)) srg_top_inst (.clk_sys_i, .sys_rst_i, .supply_low_i,
		.manual_request_n_i, .watchdog_kick_in_i, .kick_float_i, .line_sense_i, .line_i, .reset_n_o, .reset_o,
		.line_drive_o, .manual_pullup_en_o);
	srg_mcu_model srg_mcu_model_inst (.clk_sys_i, .pull_req_i(pull_req), .line_drive_i(line_drive_o),
		.line_o(line_i), .line_sense_o(line_sense_i), .self_caused_o(self_c));
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		cmp_count++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask
	task automatic wait_rst(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (reset_n_o !== lvl && cnt < lim) begin
			@(negedge clk_sys_i);
			cnt++;
		end
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask
	function automatic int hold_lo();
		return HOLD + 2;
	endfunction
	task automatic end_of_test();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	always @(negedge clk_sys_i) begin
		if (kick_en && cyc % gap == 0) begin
			watchdog_kick_in_i <= ~watchdog_kick_in_i;
		end
	end
	initial begin
		void'($urandom(32'h6C7E5928));
		gap = $urandom_range(100, WDOG - 20);
		idle(3);
		sys_rst_i = 0;
		wait_rst(1, 200, n);
		chk(n, HOLD, HOLD + 9);
		chk(manual_pullup_en_o, 1, 1);
		kick_en = 1;
		repeat (4) begin
			manual_request_n_i = 0;
			idle($urandom_range(1, 5));
			manual_request_n_i = 1;
			idle(10);
		end
		chk(reset_n_o, 1, 1);
		for (int s = 0; s < 2; s++) begin
			{supply_low_i, manual_request_n_i} = s ? 2'h3 : 2'h0;
			idle($urandom_range(20, 60));
			chk(reset_n_o, 0, 0);
			{supply_low_i, manual_request_n_i} = 2'h1;
			wait_rst(1, 200, n);
			chk(n, hold_lo(), hold_lo() + 7);
		end
		idle(3 * WDOG);
		chk(reset_n_o, 1, 1);
		kick_en = 0;
		idle(1);
		watchdog_kick_in_i = ~watchdog_kick_in_i;
		wait_rst(0, 2 * WDOG, n);
		chk(n, WDOG, WDOG + 8);
		wait_rst(1, 200, n);
		chk(n, HOLD, HOLD + 8);
		wait_rst(0, 2 * WDOG, n);
		chk(n, WDOG - 2, WDOG + 6);
		wait_rst(1, 200, n);
		kick_float_i = 1;
		idle(3 * WDOG);
		chk(reset_n_o, 1, 1);
		pull_req = 1;
		idle(1);
		pull_req = 0;
		idle(10);
		chk(reset_n_o, 0, 0);
		// Processor lets go 100 cycles after its request; rise is timed from there
		idle(90);
		n = 0;
		while (line_i !== 1'b1 && n < 100) begin
			idle(1);
			n++;
		end
		chk(n, 0, srg_pkg::LINE_SAMPLE_CYC);
		// Hold-off is shorter than the processor's own pull, so it sees itself as the cause
		idle(60);
		chk(self_c, 1, 1);
		wait_rst(1, 400, n);
		chk(reset_n_o, 1, 1);
		end_of_test();
	end
endmodule
